// >>> design/ebt_bus_timing.sv
// External bus cycle generator with Wishbone timing registers
`timescale 1ns/1ps
`include "ebt_consts.svh"

module ebt_bus_timing #(
	parameter int AW = 20
) (
	// Clock, reset, enable
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	// Wishbone slave
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [3:0]        adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [31:0]       dat_i,
	output logic      [31:0]       dat_o,
	output logic                   ack_o,
	// Cycle request from the core
	input  wire logic              req_valid_i,
	input  wire ebt_pkg::ebt_kind_t req_kind_i,
	input  wire logic              req_latch_i,
	input  wire logic              req_split_i,
	input  wire logic [AW-1:0]     req_addr_i,
	input  wire logic [15:0]       req_wdata_i,
	input  wire logic [1:0]        req_be_i,
	output logic                   req_take_o,
	output logic                   done_o,
	output logic      [15:0]       rdata_o,
	// External bus pins
	input  wire logic              wait_i,
	input  wire logic [15:0]       data_i,
	output logic      [AW-1:0]     addr_o,
	output logic                   ale_o,
	output logic                   program_fetch_strobe_n_o,
	output logic                   read_strobe_n_o,
	output logic                   low_byte_write_strobe_n_o,
	output logic                   high_byte_write_strobe_n_o,
	output logic      [15:0]       data_o,
	output logic                   data_oe_n_o
);
	import ebt_pkg::*;

	// Cycle length in half clocks from a two-bit code
	function automatic logic [3:0] len_ticks(input logic [1:0] code,
		input logic extra);
		len_ticks = {1'b0, ({1'b0, code} + {2'b00, extra} + 3'h1)} << 1;
	endfunction

	// Timing registers and bus slave state
	logic [7:0]  timing_high_r;   // Read and write lengths
	logic [7:0]  timing_low_r;    // Fetch lengths, widths, hold
	logic        ack_r;           // Wishbone acknowledge
	logic [31:0] dat_r;           // Wishbone read data

	// Cycle state captured at start
	ebt_state_t  state_r;         // Idle or running
	ebt_kind_t   kind_r;          // Cycle kind
	logic        lat_r;           // Cycle has a latch phase
	logic        split_r;         // Second byte still owed
	logic        second_r;        // In second byte phase
	logic [3:0]  t_r;             // Half clock within cycle
	logic [3:0]  tot_r;           // Cycle length, half clocks
	logic [3:0]  aw_r;            // Latch strobe width
	logic [3:0]  ww_r;            // Write strobe width
	logic [3:0]  hw_r;            // Write hold length
	logic        odd_r;           // Wait stall parity
	logic [AW-1:0] adr_r;         // Cycle address
	logic [15:0] wd_r;            // Write data
	logic [1:0]  be_r;            // Byte enables

	// Pin synchronisers
	logic        wait_m_r, wait_s_r;
	logic [15:0] din_m_r, din_s_r;

	// Output flops
	logic        take_r, done_r, ale_r, fe_n_r, rd_n_r;
	logic        wrl_n_r, wrh_n_r, oe_n_r;
	logic [15:0] rdata_r;
	// Read capture waits out the two synchroniser flops
	logic        cap1_r, cap2_r;  // Capture strobe, delayed
	logic        hi1_r, hi2_r;    // Capture goes to the high byte

	// Register decode
	wire acc      = cyc_i & stb_i & ~ack_r;
	wire hit_high = adr_i == `EBT_OFS_TIMING_HIGH;
	wire hit_low  = adr_i == `EBT_OFS_TIMING_LOW;
	wire hit_stat = adr_i == `EBT_OFS_STATUS;
	wire wr_go    = ack_r & cyc_i & stb_i & we_i & sel_i[0];
	wire [31:0] rd_mux = hit_high ? {24'h000000, timing_high_r} :
		hit_low ? {24'h000000, timing_low_r} :
		hit_stat ? {27'h0000000, split_r, kind_r, lat_r,
			state_r == EBT_RUN} : 32'h00000000;

	// Configuration fields
	wire         lsel = timing_low_r[`EBT_LATCH_BIT];
	wire         wsel = timing_low_r[`EBT_WIDTH_BIT];
	wire         hsel = timing_low_r[`EBT_HOLD_BIT];
	wire [1:0]   fe_nl = timing_low_r[`EBT_FE_NL_LSB +: 2];
	wire [1:0]   fe_la = timing_low_r[`EBT_FE_LA_LSB +: 2];
	wire [1:0]   rd_nl = timing_high_r[`EBT_RD_NL_LSB +: 2];
	wire [1:0]   rd_la = timing_high_r[`EBT_RD_LA_LSB +: 2];
	wire [1:0]   wr_nl = timing_high_r[`EBT_WR_NL_LSB +: 2];
	wire [1:0]   wr_la = timing_high_r[`EBT_WR_LA_LSB +: 2];

	// Length of a new cycle; writes are 2-5 either way
	wire [1:0] len_code = req_kind_i == EBT_FETCH ?
		(req_latch_i ? fe_la : fe_nl) :
		req_kind_i == EBT_READ ? (req_latch_i ? rd_la : rd_nl) :
		(req_latch_i ? wr_la : wr_nl);
	wire [3:0] tot_new = len_ticks(len_code,
		req_latch_i | (req_kind_i == EBT_WRITE));
	wire [3:0] tot_2nd = len_ticks(rd_nl, 1'b0);

	// Strobe windows in the current half clock
	wire         act      = state_r == EBT_RUN;
	wire [3:0]   st_start = lat_r ? aw_r + 4'h1 : 4'h0;
	wire [3:0]   wr_end   = tot_r - hw_r;
	wire [3:0]   wr_start = wr_end - ww_r;
	wire         in_st    = act & (t_r >= st_start);
	wire         ale_nxt  = act & lat_r & (t_r < aw_r);
	wire         wr_on    = act & (kind_r == EBT_WRITE) &
		(t_r >= wr_start) & (t_r < wr_end);
	wire         oe_nxt   = act & (kind_r == EBT_WRITE) & in_st;

	// Wait judging point, one clock early for reads
	wire [3:0]   judge = kind_r == EBT_READ ? tot_r - 4'h3 :
		kind_r == EBT_WRITE ? wr_end - 4'h1 : tot_r - 4'h1;
	wire         judge_ok = (kind_r != EBT_READ) | (tot_r > 4'h2);
	wire         at_judge = act & judge_ok & (t_r == judge);
	wire         stall    = at_judge & (wait_s_r | odd_r);
	wire         at_end   = act & ~stall & (t_r == tot_r - 4'h1);
	wire         go_2nd   = at_end & split_r;
	wire         take     = req_valid_i & ~take_r &
		((~act) | (at_end & ~split_r));

	// Wishbone slave: ack one cycle after the strobe, one cycle long
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r         <= 1'b0;
			dat_r         <= 32'h00000000;
			timing_high_r <= `EBT_HIGH_RST;
			timing_low_r  <= `EBT_LOW_RST;
		end
		else if (ce_i)
		begin
			ack_r <= acc;
			dat_r <= acc ? rd_mux : dat_r;
			// Write lands on the edge that ends ack
			if (wr_go & hit_high)
				timing_high_r <= dat_i[7:0];
			if (wr_go & hit_low)
				timing_low_r <= dat_i[7:0];
		end
	end

	// Two-flop synchronisers on pin inputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wait_m_r <= 1'b0;
			wait_s_r <= 1'b0;
			din_m_r  <= 16'h0000;
			din_s_r  <= 16'h0000;
		end
		else if (ce_i)
		begin
			wait_m_r <= wait_i;
			wait_s_r <= wait_m_r;
			din_m_r  <= data_i;
			din_s_r  <= din_m_r;
		end
	end

	// Cycle sequencer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r  <= EBT_IDLE;
			kind_r   <= EBT_FETCH;
			lat_r    <= 1'b0;
			split_r  <= 1'b0;
			second_r <= 1'b0;
			t_r      <= 4'h0;
			tot_r    <= 4'h2;
			aw_r     <= `EBT_ALE_NARROW;
			ww_r     <= `EBT_WR_NARROW;
			hw_r     <= 4'h0;
			odd_r    <= 1'b0;
			adr_r    <= '0;
			wd_r     <= 16'h0000;
			be_r     <= 2'h0;
		end
		else if (ce_i)
		begin
			// Stalls come in pairs of half clocks
			odd_r <= stall ? ~odd_r : 1'b0;
			if (take)
			begin
				state_r  <= EBT_RUN;
				kind_r   <= req_kind_i;
				lat_r    <= req_latch_i;
				split_r  <= req_split_i & (req_kind_i == EBT_READ);
				second_r <= 1'b0;
				t_r      <= 4'h0;
				tot_r    <= tot_new;
				aw_r     <= lsel ? `EBT_ALE_WIDE : `EBT_ALE_NARROW;
				ww_r     <= wsel ? `EBT_WR_WIDE : `EBT_WR_NARROW;
				hw_r     <= hsel ? `EBT_HOLD_ON : 4'h0;
				adr_r    <= req_addr_i;
				wd_r     <= req_wdata_i;
				be_r     <= req_be_i;
			end
			else if (go_2nd)
			begin
				// Second byte runs unlatched, strobe kept low
				lat_r    <= 1'b0;
				split_r  <= 1'b0;
				second_r <= 1'b1;
				t_r      <= 4'h0;
				tot_r    <= tot_2nd;
				adr_r    <= adr_r | {{(AW-1){1'b0}}, 1'b1};
			end
			else if (at_end)
				state_r <= EBT_IDLE;
			else if (act & ~stall)
				t_r <= t_r + 4'h1;
		end
	end

	// Registered pin and handshake outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			take_r  <= 1'b0;
			done_r  <= 1'b0;
			ale_r   <= 1'b0;
			fe_n_r  <= 1'b1;
			rd_n_r  <= 1'b1;
			wrl_n_r <= 1'b1;
			wrh_n_r <= 1'b1;
			oe_n_r  <= 1'b1;
			rdata_r <= 16'h0000;
			cap1_r  <= 1'b0;
			cap2_r  <= 1'b0;
			hi1_r   <= 1'b0;
			hi2_r   <= 1'b0;
		end
		else if (ce_i)
		begin
			take_r  <= take;
			done_r  <= at_end & ~split_r;
			ale_r   <= ale_nxt;
			fe_n_r  <= ~(in_st & (kind_r == EBT_FETCH));
			rd_n_r  <= ~(in_st & (kind_r == EBT_READ));
			wrl_n_r <= ~(wr_on & be_r[0]);
			wrh_n_r <= ~(wr_on & be_r[1]);
			oe_n_r  <= ~oe_nxt;
			// Pin value of the last half clock, two flops later
			cap1_r  <= at_end & (kind_r != EBT_WRITE);
			hi1_r   <= second_r;
			cap2_r  <= cap1_r;
			hi2_r   <= hi1_r;
			if (cap2_r)
			begin
				if (hi2_r)
					rdata_r[15:8] <= din_s_r[7:0];
				else
					rdata_r <= din_s_r;
			end
		end
	end

	// Output wiring, all from flops
	assign dat_o                      = dat_r;
	assign ack_o                      = ack_r;
	assign req_take_o                 = take_r;
	assign done_o                     = done_r;
	assign rdata_o                    = rdata_r;
	assign addr_o                     = adr_r;
	assign ale_o                      = ale_r;
	assign program_fetch_strobe_n_o   = fe_n_r;
	assign read_strobe_n_o            = rd_n_r;
	assign low_byte_write_strobe_n_o  = wrl_n_r;
	assign high_byte_write_strobe_n_o = wrh_n_r;
	assign data_o                     = wd_r;
	assign data_oe_n_o                = oe_n_r;

	// Helper counters for strobe widths
	logic [3:0] ale_cnt_r, wr_cnt_r;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ale_cnt_r <= 4'h0;
			wr_cnt_r  <= 4'h0;
		end
		else if (ce_i)
		begin
			ale_cnt_r <= ale_r ? ale_cnt_r + 4'h1 : 4'h0;
			wr_cnt_r  <= ~wrl_n_r ? wr_cnt_r + 4'h1 : 4'h0;
		end
	end

	// Latch strobe width matches the cycle's setting
	a_latch_width: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i & $fell(ale_r) |-> ale_cnt_r == aw_r)
		else $error("latch strobe width wrong");
	// Unlatched fetch drives the strobe from its first half clock
	a_fetch_full: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i & act & ~lat_r & (kind_r == EBT_FETCH) |=> ~fe_n_r)
		else $error("unlatched fetch strobe missing");
	// Latched fetch keeps strobe off during the latch phase
	a_fetch_latched: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i & act & lat_r & (t_r <= aw_r) |=> fe_n_r & rd_n_r)
		else $error("strobe overlaps latch phase");
	// Write strobe width, stalls excluded
	a_write_width: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i & ~ale_r & $rose(wrl_n_r) & ~$past(wait_s_r, 2) |->
		wr_cnt_r == ww_r)
		else $error("write strobe width wrong");
	// Data still driven after the strobe when hold is set
	a_hold_data: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i & $rose(wrl_n_r) & (hw_r != 4'h0) |-> ~oe_n_r)
		else $error("write data hold lost");
	// Read strobe stays low into the second byte
	a_read_split: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i & go_2nd & ce_i |=> ~rd_n_r ##1 ~rd_n_r)
		else $error("read strobe broke between bytes");
	// Wait freezes the half clock count
	a_wait_stretch: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i & stall |=> t_r == $past(t_r))
		else $error("wait did not stretch");
	// One-clock reads are never stretched
	a_short_read: assert property (@(posedge clk_i) disable iff (rst_i)
		act & (kind_r == EBT_READ) & (tot_r == 4'h2) |-> ~stall)
		else $error("one clock read stretched");
	// Bus ack comes one cycle after a fresh strobe and lasts one
	a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i & acc |=> ack_r ##1 ~ack_r)
		else $error("bus ack timing wrong");
endmodule // ebt_bus_timing

// >>> design/ebt_consts.svh
// Offsets, field positions, reset values and timing constants
`ifndef EBT_CONSTS_SVH
`define EBT_CONSTS_SVH
// Register byte offsets
`define EBT_OFS_TIMING_HIGH 4'h0
`define EBT_OFS_TIMING_LOW  4'h4
`define EBT_OFS_STATUS      4'h8
// bus_timing_high fields
`define EBT_RD_NL_LSB 0
`define EBT_RD_LA_LSB 2
`define EBT_WR_NL_LSB 4
`define EBT_WR_LA_LSB 6
// bus_timing_low fields
`define EBT_FE_NL_LSB 0
`define EBT_FE_LA_LSB 2
`define EBT_HOLD_BIT  4
`define EBT_WIDTH_BIT 5
`define EBT_LATCH_BIT 6
// Reset values
`define EBT_HIGH_RST 8'hFF
`define EBT_LOW_RST  8'h7F
// Timing in half clocks (one clk_i cycle each)
`define EBT_ALE_NARROW 4'h1
`define EBT_ALE_WIDE   4'h3
`define EBT_WR_NARROW  4'h2
`define EBT_WR_WIDE    4'h4
`define EBT_HOLD_ON    4'h2
`endif

// >>> design/ebt_pkg.sv
// Types shared by the external bus timing block
package ebt_pkg;
	typedef enum logic [1:0] {
		EBT_FETCH = 2'h0,
		EBT_READ  = 2'h1,
		EBT_WRITE = 2'h2
	} ebt_kind_t;
	typedef enum logic [1:0] {
		EBT_IDLE = 2'h0,
		EBT_RUN  = 2'h1
	} ebt_state_t;
endpackage

// >>> tb/ebt_bus_timing_tb_top.sv
// Self-checking bench for the external bus cycle generator
`timescale 1ns/1ps
module ebt_bus_timing_tb_top;
	import ebt_pkg::*;
	logic        clk_i = 1'b0; // 125 MHz
	logic        rst_i = 1'b1; // Synchronous reset
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] dat = 32'h0;
	logic        rv = 1'b0, rl = 1'b0, rs = 1'b0;
	ebt_kind_t   rk = EBT_FETCH;
	logic [19:0] ra = 20'h12344; // Even, so split shows bit 0 rise
	logic [15:0] rwd = 16'hC35A;
	logic [3:0]  stall = 4'h0;
	logic [31:0] rdat, lo;
	logic [15:0] rdata, dout, dq, din;
	logic [19:0] aout;
	logic        ack, take, done, ale, pf_n, rd_n, wl_n, wh_n, oe_n, wt;
	int fail_count = 0, tests_run = 0;
	int ale_c, str_c, hi_c, set_c, hold_c, gap_c, fall_c, aw, t, wd, h;
	// Device under test
	ebt_bus_timing dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(4'hF), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
		.req_valid_i(rv), .req_kind_i(rk), .req_latch_i(rl),
		.req_split_i(rs), .req_addr_i(ra), .req_wdata_i(rwd),
		.req_be_i(2'b11), .req_take_o(take), .done_o(done),
		.rdata_o(rdata), .wait_i(wt), .data_i(din), .addr_o(aout),
		.ale_o(ale), .program_fetch_strobe_n_o(pf_n),
		.read_strobe_n_o(rd_n), .low_byte_write_strobe_n_o(wl_n),
		.high_byte_write_strobe_n_o(wh_n), .data_o(dout),
		.data_oe_n_o(oe_n));
	// Far-side memory
	ebt_ext_mem mem_u (.clk_i(clk_i), .stall_i(stall), .addr_i(aout),
		.fetch_n_i(pf_n), .rd_n_i(rd_n), .wrl_n_i(wl_n),
		.wrh_n_i(wh_n), .wait_o(wt), .data_o(din));
	// Free-running clock
	initial
	begin
		forever #4 clk_i = ~clk_i;
	end
	// Compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			fail_count++;
			$display("Error at %0t: seen %0h expected %0h", $time, s, e);
		end
	endtask
	// Verdict and end of run
	task automatic results();
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// A used-up wait bound ends the run
	task automatic bound(input int n, input int lim);
		if (n >= lim)
		begin
			fail_count++;
			results();
		end
	endtask
	// One classic Wishbone access; reads compare what is taken
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d, input logic [31:0] e);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		{cyc, stb} <= 2'b00;
		bound(n, 50);
		if (!w)
			chk(rdat, e);
	endtask
	// Request cycles and measure the pins in clk_i cycles
	task automatic run(input ebt_kind_t k, input logic l, input logic s,
		input int nreq);
		int n, tk, dn, post;
		logic st, pst, seen, aseen;
		{ale_c, str_c, hi_c, set_c, hold_c, gap_c, fall_c} = '0;
		{n, tk, dn, post} = '0;
		{pst, seen, aseen} = 3'b100;
		@(posedge clk_i);
		{rv, rl, rs} <= {1'b1, l, s};
		rk <= k;
		while (post < 4 && n < 300)
		begin
			@(posedge clk_i);
			n++;
			st = (k == EBT_FETCH) ? pf_n : (k == EBT_READ) ? rd_n : wl_n;
			tk += take;
			if (tk == nreq)
				rv <= 1'b0;
			dn += done;
			post += (dn == nreq);
			ale_c += ale;
			str_c += !st;
			hi_c += !wh_n;
			fall_c += pst & !st;
			set_c += !oe_n && st && !seen;
			hold_c += !oe_n && st && seen;
			gap_c += aseen && !ale && st && !seen;
			aseen |= ale;
			seen |= !st;
			if (!st)
				dq = dout;
			pst = st;
		end
		bound(n, 300);
	endtask
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 4'h0, 32'h0, 32'hFF);
		wb(1'b0, 4'h4, 32'h0, 32'h7F);
		wb(1'b1, 4'hC, 32'h5A, 32'h0);
		wb(1'b0, 4'hC, 32'h0, 32'h0);
		for (int c = 0; c < 4; c++)
		begin
			for (int w = 0; w < 2; w++)
			begin
				{aw, wd, t, h} = {w ? 3 : 1, w ? 4 : 2, 2 * c + 4, c[0] * 2};
				lo = {25'h0, w[0], w[0], c[0], c[1:0], c[1:0]};
				wb(1'b1, 4'h4, lo, 32'h0);
				wb(1'b0, 4'h4, 32'h0, lo);
				wb(1'b1, 4'h0, {24'h0, {4{c[1:0]}}}, 32'h0);
				run(EBT_FETCH, 1'b0, 1'b0, 1);
				chk(str_c, 2 * c + 2);
				run(EBT_FETCH, 1'b1, 1'b0, 1);
				chk(ale_c, aw);
				chk(str_c, t - aw - 1);
				run(EBT_READ, 1'b0, 1'b0, 1);
				chk(str_c, 2 * c + 2);
				chk(rdata, ra[15:0] ^ 16'hA5C3);
				run(EBT_READ, 1'b1, 1'b0, 1);
				chk(str_c, t - aw - 1);
				if (t - wd - h >= 0)
				begin
					run(EBT_WRITE, 1'b0, 1'b0, 1);
					chk(str_c, wd);
					chk(hi_c, wd);
					chk(hold_c, h);
					chk(set_c, t - wd - h);
					chk(dq, rwd);
				end
				if (t - wd - h - aw - 1 >= 0)
				begin
					run(EBT_WRITE, 1'b1, 1'b0, 1);
					chk(gap_c, t - wd - h - aw);
					chk(set_c, t - wd - h - aw - 1);
				end
			end
		end
		// Back-to-back fetches keep one strobe low
		wb(1'b1, 4'h4, 32'h01, 32'h0);
		run(EBT_FETCH, 1'b0, 1'b0, 2);
		chk(str_c, 8);
		chk(fall_c, 1);
		// Split read: latched low byte, unlatched high byte
		wb(1'b1, 4'h0, 32'h00, 32'h0);
		run(EBT_READ, 1'b1, 1'b1, 1);
		chk(str_c, 4);
		chk(fall_c, 1);
		chk(rdata, {(ra[7:0] | 8'h01) ^ 8'hC3, ra[7:0] ^ 8'hC3});
		// Wait stretches a long read by whole clocks only
		stall <= 4'h6;
		wb(1'b1, 4'h0, 32'h03, 32'h0);
		run(EBT_READ, 1'b0, 1'b0, 1);
		chk(str_c > 8 && str_c <= 24 && !str_c[0], 1'b1);
		wb(1'b1, 4'h0, 32'h00, 32'h0);
		run(EBT_READ, 1'b0, 1'b0, 1);
		chk(str_c, 2);
		results();
	end
endmodule // ebt_bus_timing_tb_top

// >>> tb/ebt_ext_mem.sv
// Far-side memory model: read data and wait stretching
`timescale 1ns/1ps
module ebt_ext_mem (
	// Clock and stretch length
	input  wire logic        clk_i,
	input  wire logic [3:0]  stall_i,
	// Pins seen from the far side
	input  wire logic [19:0] addr_i,
	input  wire logic        fetch_n_i,
	input  wire logic        rd_n_i,
	input  wire logic        wrl_n_i,
	input  wire logic        wrh_n_i,
	output logic             wait_o,
	output logic      [15:0] data_o
);
	logic        idle_n_r = 1'b1; // All strobes high last cycle
	logic [19:0] adr_r = 20'h0;   // Address last cycle
	logic [3:0]  cnt_r = 4'h0;    // Wait cycles still owed
	logic [15:0] last_r = 16'h0;  // Last value driven
	wire idle_n = fetch_n_i & rd_n_i & wrl_n_i & wrh_n_i;
	wire rd_on = ~fetch_n_i | ~rd_n_i;
	// Bursts and split reads give no fresh strobe edge
	wire start = (idle_n_r & ~idle_n)
		| (~fetch_n_i & (adr_r[3:0] != addr_i[3:0]))
		| (~rd_n_i & ~adr_r[0] & addr_i[0]);
	// Released bus shows the inverse, so stale data never matches
	assign data_o = rd_on ? (addr_i[15:0] ^ 16'hA5C3) : ~last_r;
	assign wait_o = (cnt_r != 4'h0);
	// Wait counter and bus history
	always_ff @(posedge clk_i)
	begin
		idle_n_r <= idle_n;
		adr_r <= addr_i;
		if (rd_on)
			last_r <= data_o;
		if (start)
			cnt_r <= stall_i;
		else if (wait_o)
			cnt_r <= cnt_r - 4'h1;
	end
endmodule // ebt_ext_mem
